//--- serial_port_pkg.sv
package serial_port_pkg;
    localparam logic [7:0] SERIAL_CONTROL_ADDR  = 8'h98;
    localparam logic [7:0] SERIAL_BUFFER_ADDR   = 8'h99;
    localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BUFFER_RESET         = 8'h00;
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_SPEED   = 5;
    localparam int CTL_REN     = 4;
    localparam int CTL_RB8     = 2;
    localparam int CTL_TI      = 1;
    localparam int CTL_RI      = 0;
    localparam logic [3:0] M0_SLOW_DIV   = 4'hC;
    localparam logic [3:0] M0_FAST_DIV   = 4'h4;
    localparam logic [3:0] T1_SLOW_PRE   = 4'hC;
    localparam logic [3:0] T1_FAST_PRE   = 4'h4;
    localparam logic [2:0] MACHINE_CLKS  = 3'h4;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_A      = 4'h7;
    localparam logic [3:0] SAMPLE_C      = 4'h9;
    localparam logic [3:0] DATA_LAST_BIT = 4'h7;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
    localparam logic [15:0] T2_MAX       = 16'hFFFF;
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic       t1_overflow;
        logic       baud_doubler;
        logic       timer1_fast_clock_select;
        logic       tx_timer2_select;
        logic       rx_timer2_select;
        logic       timer2_run;
        logic [7:0] reload_high_byte;
        logic [7:0] reload_low_byte;
    } baud_ctl_s;

    typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_M0 = 4'b0010, TX_WAIT = 4'b0100, TX_M1 = 4'b1000} tx_state_e;
    typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_M0 = 4'b0010, RX_WAIT = 4'b0100, RX_M1 = 4'b1000} rx_state_e;
endpackage

//--- serial_port.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            wptr_reg  <= push ? wptr_reg + 1'b1 : wptr_reg;
            rptr_reg  <= pop ? rptr_reg + 1'b1 : rptr_reg;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // byte_fifo

module serial_port (
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    input  wire serial_port_pkg::sfr_req_s sfr_req,
    output logic                     [7:0] sfr_rdata,
    input  wire serial_port_pkg::baud_ctl_s baud_ctl,
    input  wire logic                      serial_data_in,
    output logic                           serial_data_out,
    output logic                           serial_data_oe_n,
    output logic                           serial_out_pin,
    output logic                           t1_count_tick,
    output logic                           timer2_overflow_flag_enable,
    output logic                           timer2_ext_reload_enable
);
    import serial_port_pkg::*;

    logic        rst_meta_reg, rst_n;
    logic [7:0]  control_reg, rx_hold_reg, rdata_reg;
    tx_state_e   tx_state_reg;
    rx_state_e   rx_state_reg;
    logic [3:0]  tx_cnt_reg, tx_bit_reg, tx_div_reg, rx_cnt_reg, rx_bit_reg, t1_pre_reg;
    logic [9:0]  tx_shift_reg;
    logic [7:0]  rx_shift_reg;
    logic [1:0]  rx_samp_reg;
    logic [2:0]  wait_reg;
    logic        rx_prev_reg, t1_half_reg, t2_phase_reg, t2_ovf_reg, t1_tick_reg;
    logic        t2_norm_reg, sdo_reg, oe_n_reg, sop_reg;
    logic [15:0] t2_count_reg;
    logic        mode0, mode1, t2_baud, t1_baud_tick, tx_tick, rx_tick;
    logic [3:0]  m0_div, m0_half;
    logic        wr_ctl, wr_buf, fifo_ready, fifo_valid, fifo_pop, ti_set, ri_set, rb8_val, maj, clk_low;
    logic [7:0]  fifo_data;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    assign mode0   = control_reg[CTL_MODE_HI:CTL_MODE_LO] == 2'b00;
    assign mode1   = control_reg[CTL_MODE_HI:CTL_MODE_LO] == 2'b01;
    assign m0_div  = control_reg[CTL_SPEED] ? M0_FAST_DIV : M0_SLOW_DIV;
    assign m0_half = m0_div >> 1;
    assign wr_ctl  = sfr_req.wr && (sfr_req.addr == SERIAL_CONTROL_ADDR);
    assign wr_buf  = sfr_req.wr && (sfr_req.addr == SERIAL_BUFFER_ADDR);

    // ----------------------------------------
    // Baud generation
    // ----------------------------------------
    assign t2_baud = baud_ctl.tx_timer2_select || baud_ctl.rx_timer2_select;
    assign t1_baud_tick = baud_ctl.t1_overflow && (baud_ctl.baud_doubler || t1_half_reg);
    assign tx_tick = baud_ctl.tx_timer2_select ? t2_ovf_reg : t1_baud_tick;
    assign rx_tick = baud_ctl.rx_timer2_select ? t2_ovf_reg : t1_baud_tick;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t1_pre_reg  <= '0;
            t1_tick_reg <= 1'b0;
            t1_half_reg <= 1'b0;
        end else begin
            t1_tick_reg <= t1_pre_reg == '0;
            if (t1_pre_reg == '0) begin
                t1_pre_reg <= (baud_ctl.timer1_fast_clock_select ? T1_FAST_PRE : T1_SLOW_PRE) - 4'h1;
            end else begin
                t1_pre_reg <= t1_pre_reg - 4'h1;
            end
            if (baud_ctl.t1_overflow) begin
                t1_half_reg <= !t1_half_reg;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t2_count_reg <= '0;
            t2_phase_reg <= 1'b0;
            t2_ovf_reg   <= 1'b0;
            t2_norm_reg  <= 1'b1;
        end else begin
            t2_norm_reg  <= !t2_baud;
            t2_ovf_reg   <= 1'b0;
            t2_phase_reg <= t2_baud && baud_ctl.timer2_run && !t2_phase_reg;
            if (!t2_baud || !baud_ctl.timer2_run) begin
                t2_count_reg <= {baud_ctl.reload_high_byte, baud_ctl.reload_low_byte};
            end else if (t2_phase_reg) begin
                if (t2_count_reg == T2_MAX) begin
                    t2_count_reg <= {baud_ctl.reload_high_byte, baud_ctl.reload_low_byte};
                    t2_ovf_reg   <= 1'b1;
                end else begin
                    t2_count_reg <= t2_count_reg + 16'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // buffer writes feed the transmit path.
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clock(clock), .rst_n(rst_n), .in_valid(wr_buf), .in_ready(fifo_ready), .in_data(sfr_req.wdata),
        .out_valid(fifo_valid), .out_ready(fifo_pop), .out_data(fifo_data)
    );
    assign fifo_pop = (tx_state_reg == TX_IDLE) && ((mode0 && rx_state_reg == RX_IDLE) || mode1);
    assign ti_set   = ((tx_state_reg == TX_M0) && tx_cnt_reg == m0_div - 4'h1 && tx_bit_reg == DATA_LAST_BIT)
                   || ((tx_state_reg == TX_M1) && tx_tick && tx_div_reg == OVERSAMPLE_LAST
                       && tx_bit_reg == FRAME_LAST_BIT);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= '0;
            tx_bit_reg   <= '0;
            tx_div_reg   <= '0;
            tx_shift_reg <= '1;
        end else begin
            if (tx_tick) begin
                tx_div_reg <= tx_div_reg + 4'h1;
            end
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_cnt_reg <= '0;
                    tx_bit_reg <= '0;
                    if (fifo_valid && fifo_pop) begin
                        tx_shift_reg <= mode0 ? {2'b11, fifo_data} : {1'b1, fifo_data, 1'b0};
                        tx_state_reg <= mode0 ? TX_M0 : TX_WAIT;
                    end
                end
                TX_M0: begin
                    tx_cnt_reg <= tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg == m0_div - 4'h1) begin
                        tx_cnt_reg   <= '0;
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        if (tx_bit_reg == DATA_LAST_BIT) begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                TX_WAIT: begin
                    if (tx_tick && tx_div_reg == OVERSAMPLE_LAST) begin
                        tx_state_reg <= TX_M1;
                    end
                end
                TX_M1: begin
                    if (tx_tick && tx_div_reg == OVERSAMPLE_LAST) begin
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        if (tx_bit_reg == FRAME_LAST_BIT) begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    assign maj    = (rx_samp_reg[1] & rx_samp_reg[0]) | (rx_samp_reg[1] & serial_data_in)
                  | (rx_samp_reg[0] & serial_data_in);
    assign rb8_val = maj;
    assign ri_set = ((rx_state_reg == RX_WAIT) && wait_reg == MACHINE_CLKS - 3'h1)
                 || ((rx_state_reg == RX_M1) && rx_tick && rx_cnt_reg == SAMPLE_C && rx_bit_reg == FRAME_LAST_BIT
                     && !control_reg[CTL_RI] && (!control_reg[CTL_SPEED] || maj));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= '0;
            rx_bit_reg   <= '0;
            rx_shift_reg <= '0;
            rx_samp_reg  <= '0;
            rx_prev_reg  <= 1'b1;
            wait_reg     <= '0;
            rx_hold_reg  <= BUFFER_RESET;
        end else begin
            if (rx_tick) begin
                rx_prev_reg <= serial_data_in;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_cnt_reg <= '0;
                    rx_bit_reg <= '0;
                    wait_reg   <= '0;
                    if (mode0 && control_reg[CTL_REN] && !control_reg[CTL_RI] && tx_state_reg == TX_IDLE
                        && !fifo_valid) begin
                        rx_state_reg <= RX_M0;
                    end else if (mode1 && control_reg[CTL_REN] && rx_tick && rx_prev_reg && !serial_data_in) begin
                        rx_state_reg <= RX_M1;
                    end
                end
                RX_M0: begin
                    rx_cnt_reg <= rx_cnt_reg + 4'h1;
                    if (rx_cnt_reg == m0_half) begin
                        rx_shift_reg <= {serial_data_in, rx_shift_reg[7:1]};
                    end
                    if (rx_cnt_reg == m0_div - 4'h1) begin
                        rx_cnt_reg <= '0;
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == DATA_LAST_BIT) begin
                            rx_state_reg <= RX_WAIT;
                        end
                    end
                end
                RX_WAIT: begin
                    wait_reg <= wait_reg + 3'h1;
                    if (ri_set) begin
                        rx_hold_reg  <= rx_shift_reg;
                        rx_state_reg <= RX_IDLE;
                    end
                end
                RX_M1: begin
                    if (rx_tick) begin
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg >= SAMPLE_A && rx_cnt_reg < SAMPLE_C) begin
                            rx_samp_reg <= {rx_samp_reg[0], serial_data_in};
                        end
                        if (rx_cnt_reg == SAMPLE_C) begin
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == '0 && maj) begin
                                rx_state_reg <= RX_IDLE;
                            end else if (rx_bit_reg == FRAME_LAST_BIT) begin
                                if (ri_set) begin
                                    rx_hold_reg <= rx_shift_reg;
                                end
                                rx_state_reg <= RX_IDLE;
                            end else if (rx_bit_reg != '0) begin
                                rx_shift_reg <= {maj, rx_shift_reg[7:1]};
                            end
                        end
                        if (rx_cnt_reg == OVERSAMPLE_LAST) begin
                            rx_cnt_reg <= '0;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Registers and pins
    // ----------------------------------------
    assign clk_low = ((tx_state_reg == TX_M0) && tx_cnt_reg < m0_half)
                  || ((rx_state_reg == RX_M0) && rx_cnt_reg < m0_half);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= SERIAL_CONTROL_RESET;
            rdata_reg   <= '0;
        end else begin
            if (wr_ctl) begin
                control_reg <= sfr_req.wdata;
            end
            // A hardware set wins over a same-cycle clear.
            if (ti_set) begin
                control_reg[CTL_TI] <= 1'b1;
            end
            if (ri_set) begin
                control_reg[CTL_RI] <= 1'b1;
                if (rx_state_reg == RX_M1) begin
                    control_reg[CTL_RB8] <= rb8_val;
                end
            end
            if (sfr_req.rd) begin
                if (sfr_req.addr == SERIAL_CONTROL_ADDR) begin
                    rdata_reg <= control_reg;
                end else if (sfr_req.addr == SERIAL_BUFFER_ADDR) begin
                    rdata_reg <= rx_hold_reg;
                end else begin
                    rdata_reg <= '0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sdo_reg  <= 1'b1;
            oe_n_reg <= 1'b1;
            sop_reg  <= 1'b1;
        end else begin
            // mode 0: clock on out pin, data on data pin.
            sdo_reg  <= tx_shift_reg[0];
            oe_n_reg <= tx_state_reg != TX_M0;
            // mode 0 drives its own shift clock.
            sop_reg  <= mode0 ? !clk_low : ((tx_state_reg == TX_M1) ? tx_shift_reg[0] : 1'b1);
        end
    end

    assign sfr_rdata                   = rdata_reg;
    assign serial_data_out             = sdo_reg;
    assign serial_data_oe_n            = oe_n_reg;
    assign serial_out_pin              = sop_reg;
    assign t1_count_tick               = t1_tick_reg;
    assign timer2_overflow_flag_enable = t2_norm_reg;
    assign timer2_ext_reload_enable    = t2_norm_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_m0_tx_drives;
        @(posedge clock) disable iff (!rst_n) (tx_state_reg == TX_M0) |=> !serial_data_oe_n;
    endproperty
    a_m0_tx_drives: assert property (p_m0_tx_drives) else $error("data pin not driven in mode 0 send");

    property p_m0_rx_releases;
        @(posedge clock) disable iff (!rst_n) (rx_state_reg == RX_M0) |=> serial_data_oe_n;
    endproperty
    a_m0_rx_releases: assert property (p_m0_rx_releases) else $error("data pin driven in mode 0 receive");

    property p_ri_after_wait;
        @(posedge clock) disable iff (!rst_n) $rose(rx_state_reg == RX_WAIT) |-> ##4 control_reg[CTL_RI];
    endproperty
    a_ri_after_wait: assert property (p_ri_after_wait) else $error("done flag late after eighth bit");

    property p_ri_halts_m0;
        @(posedge clock) disable iff (!rst_n)
            (control_reg[CTL_RI] && rx_state_reg == RX_IDLE) |=> (rx_state_reg != RX_M0);
    endproperty
    a_ri_halts_m0: assert property (p_ri_halts_m0) else $error("receive restarted while done flag set");

    property p_t2_block;
        @(posedge clock) disable iff (!rst_n) t2_baud |=> !timer2_overflow_flag_enable && !timer2_ext_reload_enable;
    endproperty
    a_t2_block: assert property (p_t2_block) else $error("timer 2 flag not blocked in baud mode");

    property p_t1_fast_pre;
        @(posedge clock) disable iff (!rst_n)
            ($rose(t1_count_tick) && baud_ctl.timer1_fast_clock_select && $past(baud_ctl.timer1_fast_clock_select))
            |=> (!t1_count_tick)[*3] ##1 t1_count_tick;
    endproperty
    a_t1_fast_pre: assert property (p_t1_fast_pre) else $error("timer 1 prescale not four");

    property p_read_hold;
        @(posedge clock) disable iff (!rst_n)
            (sfr_req.rd && sfr_req.addr == SERIAL_BUFFER_ADDR) |=> sfr_rdata == $past(rx_hold_reg);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("buffer read not from holding register");

    property p_hold_with_ri;
        @(posedge clock) disable iff (!rst_n) $changed(rx_hold_reg) |-> $rose(control_reg[CTL_RI]);
    endproperty
    a_hold_with_ri: assert property (p_hold_with_ri) else $error("holding register changed without done flag");

    c_m0_tx: cover property (@(posedge clock) disable iff (!rst_n) $rose(control_reg[CTL_TI]) && mode0);
    c_m0_rx: cover property (@(posedge clock) disable iff (!rst_n) $rose(control_reg[CTL_RI]) && mode0);
    c_m1_rx: cover property (@(posedge clock) disable iff (!rst_n) $rose(control_reg[CTL_RI]) && mode1);
endmodule // serial_port

//--- serial_peer.sv
`timescale 1ns/1ps
// -----
// Shift register peer for mode 0, echo peer for mode 1.
// -----
module serial_peer (
    input  wire logic       clock,
    input  wire logic       loop,
    input  wire logic       clr,
    input  wire logic [7:0] tx_byte,
    input  wire logic       data_out,
    input  wire logic       data_oe_n,
    input  wire logic       shift_clk,
    output logic            data_in,
    output logic      [7:0] got,
    output int              rises,
    output int              period
);
    int   cnt  = 0;
    int   last = 0;
    logic prev = 1'b1;
    logic held = 1'b1;
    initial got = 8'h00;
    initial rises = 0;
    initial period = 0;
    always @(posedge clock) begin
        prev <= shift_clk;
        cnt <= cnt + 1;
        if (clr) begin
            rises <= 0;
            held <= tx_byte[0];
        end
        if (shift_clk && !prev) begin
            if (!data_oe_n) got <= {data_out, got[7:1]};
            rises <= rises + 1;
            period <= cnt - last;
            last <= cnt;
        end
        // new bit at clock fall, toggles at each fall after eight
        if (!shift_clk && prev) held <= (rises < 8) ? tx_byte[rises[2:0]] : ~held;
    end
    assign data_in = loop ? shift_clk : held;
endmodule // serial_peer

//--- test_serial_port.sv
`timescale 1ns/1ps
module test_serial_port;
    import serial_port_pkg::*;
    logic       clock  = 1'b0;
    logic       arst_n = 1'b0;
    sfr_req_s   rq     = '0;
    baud_ctl_s  bc     = '0;
    logic       loop   = 1'b0;
    logic       clr    = 1'b0;
    logic [7:0] rdata, got, rd_val;
    logic       sdi, sdo, oe_n, sop, tick, ofe, ere;
    int         rises, period, t0;
    int         miscompares = 0;
    int         check_count = 0;
    always #4 clock = ~clock;
    // rollovers stand in for the outside timer
    always @(posedge clock) bc.t1_overflow <= loop & ~bc.t1_overflow;
    serial_port DUT (.clock(clock), .arst_n(arst_n), .sfr_req(rq), .sfr_rdata(rdata), .baud_ctl(bc),
        .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_n(oe_n), .serial_out_pin(sop),
        .t1_count_tick(tick), .timer2_overflow_flag_enable(ofe), .timer2_ext_reload_enable(ere));
    serial_peer peer (.clock(clock), .loop(loop), .clr(clr), .tx_byte(8'h3C), .data_out(sdo),
        .data_oe_n(oe_n), .shift_clk(sop), .data_in(sdi), .got(got), .rises(rises), .period(period));
    // -----
    // Access and check tasks.
    // -----
    task automatic tally_and_finish;
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 rq = '{addr: a, wr: w, rd: ~w, wdata: d};
        @(posedge clock);
        #1 rq = '0;
        @(posedge clock);
        #1 rd_val = rdata;
    endtask
    task automatic wait_flag(input int b);
        for (int i = 0; i < 400; i++) begin
            acc(1'b0, SERIAL_CONTROL_ADDR, 8'h00);
            if (rd_val[b] === 1'b1) return;
        end
        miscompares++;
        tally_and_finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        #1 arst_n = 1'b1;
        repeat (5) @(posedge clock);
        acc(1'b0, SERIAL_CONTROL_ADDR, 8'h00);
        cmp(rd_val, SERIAL_CONTROL_RESET);
        acc(1'b0, 8'h9A, 8'h00);
        cmp(rd_val, 8'h00);
        for (int s = 0; s < 2; s++) begin
            acc(1'b1, SERIAL_CONTROL_ADDR, s ? 8'h20 : 8'h00);
            acc(1'b1, SERIAL_BUFFER_ADDR, 8'hA5 ^ s[7:0]);
            wait_flag(CTL_TI);
            cmp(got, 8'hA5 ^ s);
            cmp(period, s ? 4 : 12);
        end
        clr = 1'b1;
        @(posedge clock);
        #1 clr = 1'b0;
        acc(1'b1, SERIAL_CONTROL_ADDR, 8'h30);
        wait_flag(CTL_RI);
        acc(1'b0, SERIAL_BUFFER_ADDR, 8'h00);
        cmp(rd_val, 8'h3C);
        repeat (60) @(posedge clock);
        #1 cmp(rises, 8);
        for (int f = 0; f < 2; f++) begin
            bc.timer1_fast_clock_select = f[0];
            repeat (24) @(posedge clock);
            t0 = 0;
            repeat (96) begin
                @(posedge clock);
                #1 t0 += tick;
            end
            cmp(t0, f ? 24 : 8);
        end
        bc.rx_timer2_select = 1'b1;
        repeat (3) @(posedge clock);
        #1 cmp({ofe, ere}, 2'b00);
        bc.reload_high_byte = 8'hFF;
        bc.reload_low_byte = 8'hFE;
        loop = 1'b1;
        for (int d = 0; d < 3; d++) begin
            bc.baud_doubler = (d == 0);
            bc.tx_timer2_select = (d == 2);
            bc.rx_timer2_select = (d == 2);
            bc.timer2_run = (d == 2);
            acc(1'b1, SERIAL_CONTROL_ADDR, 8'h50);
            cmp({ofe, ere}, (d == 2) ? 2'b00 : 2'b11);
            acc(1'b1, SERIAL_BUFFER_ADDR, 8'h96 ^ d[7:0]);
            wait_flag(CTL_RI);
            cmp(period, d ? 192 : 96);
            acc(1'b0, SERIAL_BUFFER_ADDR, 8'h00);
            cmp(rd_val, 8'h96 ^ d);
            acc(1'b0, SERIAL_CONTROL_ADDR, 8'h00);
            cmp(rd_val[CTL_RB8], 1'b1);
        end
        tally_and_finish;
    end
endmodule // test_serial_port
